/* hbfs_supervisor.sv */
/*
  Fault supervisor and power-mode sequencer of a four-channel half-bridge
  driver, with an AXI4-Lite register slave.
  Assumes all condition inputs are synchronous levels from analog monitors
  and that the fault pin wire is resolved outside from the enable.
*/
`timescale 1ns/1ps
// How it works
// - Supply lockout tri-states outputs, pulls fault low, stops pump.
// - Bridges and fault pin recover when supply rises above lockout.
// - Supply below digital reset level resets logic, releases fault pin.
// - Pump undervoltage tri-states outputs, pulls fault low, pump keeps running.
// - Logic supply failure tri-states, stops pump, resets logic, no fault.
// - Limit held past filter time flags fault, disables only that bridge.
// - High-side and low-side limits both count as overcurrent.
// - Select low: overcurrent stays latched until reset pulse or power cycle.
// - Select high: bridge returns after retry delay once overcurrent gone.
// - Variant without select pin always latches overcurrent.
// - Overtemperature disables all bridges, pulls fault low, stops pump.
// - Select low: overtemperature latched until reset pulse after cooling.
// - Select high or no pin: overtemperature clears once cooled.
// - Fault pin is open-drain, low while any fault outside sleep, released at reset.
// - Sleep pin low for the entry delay shuts bridges, regulator, pump.
// - Sleep pin high wakes; inputs ready only after wake delay.
// - Operating only with sleep pin high; supply above lockout needed only to leave waking.
// - Sleep low pulse over 20 us clears latched faults.
// - Reset pulse leaves pump and other blocks untouched.
module hbfs_supervisor #(
  parameter int HAS_RECOVERY_SELECT = 1,
  parameter int OC_FILTER_CYC       = hbfs_pkg::OC_FILTER_CYC,
  parameter int RETRY_CYC           = hbfs_pkg::RETRY_CYC,
  parameter int SLEEP_ENTRY_CYC     = hbfs_pkg::SLEEP_ENTRY_CYC,
  parameter int WAKE_CYC            = hbfs_pkg::WAKE_CYC
) (
  input  wire logic                               clock,
  input  wire logic                               rst_b,
  input  wire logic                               motorSupplyLockout,
  input  wire logic                               supplyBelowReset,
  input  wire logic                               logicSupplyFail,
  input  wire logic                               pumpUndervoltage,
  input  wire logic [hbfs_pkg::NUM_BRIDGES-1:0]   currentLimitHs,
  input  wire logic [hbfs_pkg::NUM_BRIDGES-1:0]   currentLimitLs,
  input  wire logic                               overtemperatureShutdown,
  input  wire logic                               faultRecoverySelect,
  input  wire logic                               sleepRequestN,
  input  wire logic                               faultIndicatorNI,
  output logic                                    faultIndicatorNO,
  output logic                                    faultIndicatorNOe,
  output logic [hbfs_pkg::NUM_BRIDGES-1:0]        bridgeEnable,
  output logic                                    chargePumpEnable,
  output logic                                    regulatorEnable,
  output logic                                    readyForInputs,
  input  wire logic                               awvalid,
  output logic                                    awready,
  input  wire logic [hbfs_pkg::ADDR_W-1:0]        awaddr,
  input  wire logic                               wvalid,
  output logic                                    wready,
  input  wire logic [31:0]                        wdata,
  input  wire logic [3:0]                         wstrb,
  output logic                                    bvalid,
  input  wire logic                               bready,
  output logic [1:0]                              bresp,
  input  wire logic                               arvalid,
  output logic                                    arready,
  input  wire logic [hbfs_pkg::ADDR_W-1:0]        araddr,
  output logic                                    rvalid,
  input  wire logic                               rready,
  output logic [31:0]                             rdata,
  output logic [1:0]                              rresp
);
  // ==========================================================================
  // Timer limits
  localparam int TW = hbfs_pkg::TIMER_W;
  localparam int NB = hbfs_pkg::NUM_BRIDGES;
  localparam logic [TW-1:0] OC_LIM    = OC_FILTER_CYC[TW-1:0];
  localparam logic [TW-1:0] RETRY_LIM = RETRY_CYC[TW-1:0];
  localparam logic [TW-1:0] SLEEP_LIM = SLEEP_ENTRY_CYC[TW-1:0];
  localparam logic [TW-1:0] WAKE_LIM  = WAKE_CYC[TW-1:0];
  localparam logic [TW-1:0] PULSE_LIM = hbfs_pkg::PULSE_MIN_CYC[TW-1:0];

  // ==========================================================================
  // Declarations
  hbfs_pkg::hbfs_state_t stateFf;
  hbfs_pkg::hbfs_state_t nxt_state;
  logic          logicReset;
  logic          autoOc;
  logic          autoOt;
  logic          sleepNPrevFf;
  logic          pulseSeenFf;
  logic          pulseDone;
  logic          sleepDone;
  logic          wakeDone;
  logic          clearLatched;
  logic          otLatchedFf;
  logic          otActive;
  logic [NB-1:0] ocFault;
  logic          anyFault;
  logic          asleep;
  logic          driveOk;
  logic [3:0]    bridgeMaskFf;
  logic [NB-1:0] bridgeEnableFf;
  logic          chargePumpEnableFf;
  logic          regulatorEnableFf;
  logic          faultOeFf;
  logic          readyFf;
  logic          awHeldFf;
  logic          wHeldFf;
  logic [7:0]    awAddrFf;
  logic [31:0]   wDataFf;
  logic [3:0]    wStrbFf;
  logic          bvalidFf;
  logic [1:0]    brespFf;
  logic          rvalidFf;
  logic [31:0]   rdataFf;
  logic [1:0]    rrespFf;
  logic [31:0]   statusWord;
  logic          doWrite;

  // ==========================================================================
  // Supply and mode qualifiers
  assign logicReset = supplyBelowReset || logicSupplyFail;
  assign autoOc = (HAS_RECOVERY_SELECT != 0) && faultRecoverySelect;
  assign autoOt = (HAS_RECOVERY_SELECT == 0) || faultRecoverySelect;
  assign asleep = (stateFf == hbfs_pkg::ST_ASLEEP);

  // ==========================================================================
  // Sleep pin timing
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sleepNPrevFf <= 1'h1;
      pulseSeenFf  <= 1'h0;
    end else begin
      sleepNPrevFf <= sleepRequestN;
      pulseSeenFf  <= pulseDone;
    end
  end

  hbfs_timer u_pulse (
    .clock (clock),
    .rst_b (rst_b),
    .run   (!sleepRequestN),
    .limit (PULSE_LIM),
    .done  (pulseDone)
  );

  hbfs_timer u_sleep (
    .clock (clock),
    .rst_b (rst_b),
    .run   (stateFf == hbfs_pkg::ST_ENTERING),
    .limit (SLEEP_LIM),
    .done  (sleepDone)
  );

  hbfs_timer u_wake (
    .clock (clock),
    .rst_b (rst_b),
    .run   (stateFf == hbfs_pkg::ST_WAKING),
    .limit (WAKE_LIM),
    .done  (wakeDone)
  );

  // Pulse timer clears on the rise, so its done flag is kept one cycle
  assign clearLatched = sleepRequestN && !sleepNPrevFf && pulseSeenFf;

  // ==========================================================================
  // Power mode sequencing
  always_comb begin
    nxt_state = stateFf;
    unique case (stateFf)
      hbfs_pkg::ST_AWAKE: begin
        if (!sleepRequestN) begin
          nxt_state = hbfs_pkg::ST_ENTERING;
        end
      end
      hbfs_pkg::ST_ENTERING: begin
        if (sleepRequestN) begin
          nxt_state = hbfs_pkg::ST_AWAKE;
        end else if (sleepDone) begin
          nxt_state = hbfs_pkg::ST_ASLEEP;
        end
      end
      hbfs_pkg::ST_ASLEEP: begin
        if (sleepRequestN) begin
          nxt_state = hbfs_pkg::ST_WAKING;
        end
      end
      hbfs_pkg::ST_WAKING: begin
        if (!sleepRequestN) begin
          nxt_state = hbfs_pkg::ST_ENTERING;
        end else if (wakeDone && !motorSupplyLockout) begin
          nxt_state = hbfs_pkg::ST_AWAKE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stateFf <= hbfs_pkg::ST_WAKING;
    end else if (logicReset) begin
      stateFf <= hbfs_pkg::ST_WAKING;
    end else begin
      stateFf <= nxt_state;
    end
  end

  // ==========================================================================
  // Overcurrent per bridge
  for (genvar gi = 0; gi < NB; gi++) begin : g_oc
    hbfs_oc_channel u_oc (
      .clock        (clock),
      .rst_b        (rst_b),
      .logicReset   (logicReset),
      .hsLimit      (currentLimitHs[gi]),
      .lsLimit      (currentLimitLs[gi]),
      .autoRetry    (autoOc),
      .clearLatched (clearLatched),
      .filterLimit  (OC_LIM),
      .retryLimit   (RETRY_LIM),
      .ocFaultFf    (ocFault[gi])
    );
  end

  // ==========================================================================
  // Overtemperature latch, set wins over clear
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      otLatchedFf <= 1'h0;
    end else if (logicReset) begin
      otLatchedFf <= 1'h0;
    end else if (overtemperatureShutdown) begin
      otLatchedFf <= 1'h1;
    end else if (autoOt || clearLatched) begin
      otLatchedFf <= 1'h0;
    end
  end

  assign otActive = overtemperatureShutdown || otLatchedFf;
  assign anyFault = motorSupplyLockout || pumpUndervoltage || otActive ||
                    (|ocFault);

  // ==========================================================================
  // Output stage enables
  assign driveOk = !logicReset && !motorSupplyLockout && !pumpUndervoltage &&
                   !otActive && !asleep;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bridgeEnableFf <= '0;
    end else begin
      bridgeEnableFf <= {NB{driveOk}} & ~ocFault & bridgeMaskFf;
    end
  end

  // Pump ignores the clear pulse and pump undervoltage
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      chargePumpEnableFf <= 1'h0;
    end else begin
      chargePumpEnableFf <= !logicReset && !motorSupplyLockout &&
                            !otActive && !asleep;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      regulatorEnableFf <= 1'h1;
    end else begin
      regulatorEnableFf <= !asleep;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      faultOeFf <= 1'h0;
    end else begin
      faultOeFf <= !logicReset && !asleep && anyFault;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readyFf <= 1'h0;
    end else begin
      readyFf <= (nxt_state == hbfs_pkg::ST_AWAKE) && !logicReset;
    end
  end

  assign bridgeEnable      = bridgeEnableFf;
  assign chargePumpEnable  = chargePumpEnableFf;
  assign regulatorEnable   = regulatorEnableFf;
  assign faultIndicatorNO  = 1'h0;
  assign faultIndicatorNOe = faultOeFf;
  assign readyForInputs    = readyFf;

  // ==========================================================================
  // Register bus write path
  assign awready = !awHeldFf && !bvalidFf;
  assign wready  = !wHeldFf && !bvalidFf;
  assign doWrite = awHeldFf && wHeldFf && !bvalidFf;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      awHeldFf <= 1'h0;
      awAddrFf <= 8'h00;
    end else if (awvalid && awready) begin
      awHeldFf <= 1'h1;
      awAddrFf <= awaddr;
    end else if (doWrite) begin
      awHeldFf <= 1'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wHeldFf <= 1'h0;
      wDataFf <= 32'h0000_0000;
      wStrbFf <= 4'h0;
    end else if (wvalid && wready) begin
      wHeldFf <= 1'h1;
      wDataFf <= wdata;
      wStrbFf <= wstrb;
    end else if (doWrite) begin
      wHeldFf <= 1'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bvalidFf <= 1'h0;
      brespFf  <= hbfs_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalidFf <= 1'h1;
      brespFf  <= (awAddrFf == hbfs_pkg::CTRL_OFFSET ||
                   awAddrFf == hbfs_pkg::STATUS_OFFSET) ?
                  hbfs_pkg::RESP_OKAY : hbfs_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalidFf <= 1'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bridgeMaskFf <= hbfs_pkg::CTRL_RESET;
    end else if (doWrite && awAddrFf == hbfs_pkg::CTRL_OFFSET && wStrbFf[0]) begin
      bridgeMaskFf <= wDataFf[3:0];
    end
  end

  assign bvalid = bvalidFf;
  assign bresp  = brespFf;

  // ==========================================================================
  // Register bus read path
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[hbfs_pkg::ST_OC_LSB +: NB] = ocFault;
    statusWord[hbfs_pkg::ST_OT_BIT]       = otActive;
    statusWord[hbfs_pkg::ST_MOTOR_SUPPLY_LOCKOUT_BIT]     = motorSupplyLockout;
    statusWord[hbfs_pkg::ST_PUMP_UNDERVOLTAGE_BIT]     = pumpUndervoltage;
    statusWord[hbfs_pkg::ST_LRST_BIT]     = logicReset;
    statusWord[hbfs_pkg::ST_STATE_LSB +: 2] = stateFf;
    statusWord[hbfs_pkg::ST_PIN_BIT]      = faultIndicatorNI;
    statusWord[hbfs_pkg::ST_AUTO_BIT]     = autoOc;
  end

  assign arready = !rvalidFf;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rvalidFf <= 1'h0;
      rdataFf  <= 32'h0000_0000;
      rrespFf  <= hbfs_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalidFf <= 1'h1;
      rrespFf  <= hbfs_pkg::RESP_OKAY;
      if (araddr == hbfs_pkg::CTRL_OFFSET) begin
        rdataFf <= {28'h0000000, bridgeMaskFf};
      end else if (araddr == hbfs_pkg::STATUS_OFFSET) begin
        rdataFf <= statusWord;
      end else begin
        rdataFf <= 32'h0000_0000;
        rrespFf <= hbfs_pkg::RESP_SLVERR;
      end
    end else if (rready) begin
      rvalidFf <= 1'h0;
    end
  end

  assign rvalid = rvalidFf;
  assign rdata  = rdataFf;
  assign rresp  = rrespFf;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_inSleep2;
    stateFf == hbfs_pkg::ST_ASLEEP ##1 stateFf == hbfs_pkg::ST_ASLEEP;
  endsequence

  sequence s_lockoutAwake;
    motorSupplyLockout && !logicReset && !asleep;
  endsequence

  AST_LOCKOUT: assert property (s_lockoutAwake |=>
    bridgeEnableFf == '0 && !chargePumpEnableFf && faultOeFf)
    else $error("lockout did not shut outputs and pull fault");
  AST_DIGRESET: assert property (supplyBelowReset |=> !faultOeFf)
    else $error("fault pin held low below digital reset");
  AST_PUMPUV: assert property (pumpUndervoltage && !logicReset && !asleep &&
    !motorSupplyLockout && !otActive |=> bridgeEnableFf == '0 &&
    chargePumpEnableFf && faultOeFf)
    else $error("pump undervoltage response wrong");
  AST_LOGICFAIL: assert property (logicSupplyFail |=>
    bridgeEnableFf == '0 && !chargePumpEnableFf && !faultOeFf)
    else $error("logic supply failure response wrong");
  AST_OCOFF: assert property (ocFault != '0 |=>
    (bridgeEnableFf & $past(ocFault)) == '0)
    else $error("overcurrent bridge not disabled");
  AST_OCLATCH: assert property (!autoOc && !clearLatched &&
    !logicReset |=> (ocFault & $past(ocFault)) == $past(ocFault))
    else $error("latched overcurrent released without pulse");
  AST_OVERTEMPERATURE_SHUTDOWN: assert property (overtemperatureShutdown |=>
    bridgeEnableFf == '0 && !chargePumpEnableFf)
    else $error("overtemperature did not stop bridges and pump");
  AST_SLEEP: assert property (s_inSleep2 |-> !regulatorEnableFf &&
    bridgeEnableFf == '0 && !chargePumpEnableFf)
    else $error("blocks left on in sleep");
  AST_READY: assert property ($rose(readyFf) |-> sleepRequestN &&
    !motorSupplyLockout)
    else $error("operating entered without wake conditions");
  AST_BHOLD: assert property (bvalidFf && !bready |=> bvalidFf && $stable(brespFf))
    else $error("write response dropped before taken");
endmodule : hbfs_supervisor

/* hbfs_pkg.sv */
/*
  Constants, register map and state encoding of the half-bridge fault
  supervisor. Assumes a 200 MHz clock; all times are converted to cycles.
*/
package hbfs_pkg;
  // ==========================================================================
  // Time base
  localparam int CLK_MHZ        = 200;
  localparam int TIMER_W        = 20;
  localparam int PULSE_MIN_US   = 20;
  localparam int PULSE_MIN_CYC  = PULSE_MIN_US * CLK_MHZ;
  localparam int OC_FILTER_US   = 1;
  localparam int OC_FILTER_CYC  = OC_FILTER_US * CLK_MHZ;
  localparam int RETRY_US       = 1000;
  localparam int RETRY_CYC      = RETRY_US * CLK_MHZ;
  localparam int SLEEP_ENTRY_US = 120;
  localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ;
  localparam int WAKE_US        = 1000;
  localparam int WAKE_CYC       = WAKE_US * CLK_MHZ;

  // ==========================================================================
  // Bridges
  localparam int NUM_BRIDGES = 4;

  // ==========================================================================
  // Register bus
  localparam int              ADDR_W        = 8;
  localparam logic [7:0]      CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]      STATUS_OFFSET = 8'h04;
  localparam logic [3:0]      CTRL_RESET    = 4'hF;
  localparam logic [1:0]      RESP_OKAY     = 2'h0;
  localparam logic [1:0]      RESP_SLVERR   = 2'h2;
  localparam int              ST_OC_LSB     = 0;
  localparam int              ST_OT_BIT     = 4;
  localparam int              ST_MOTOR_SUPPLY_LOCKOUT_BIT   = 5;
  localparam int              ST_PUMP_UNDERVOLTAGE_BIT   = 6;
  localparam int              ST_LRST_BIT   = 7;
  localparam int              ST_STATE_LSB  = 8;
  localparam int              ST_PIN_BIT    = 10;
  localparam int              ST_AUTO_BIT   = 11;

  // ==========================================================================
  // Power mode states, Gray along asleep-waking-awake-entering
  typedef enum logic [1:0] {
    ST_ASLEEP   = 2'h0,
    ST_WAKING   = 2'h1,
    ST_AWAKE    = 2'h3,
    ST_ENTERING = 2'h2
  } hbfs_state_t;
endpackage : hbfs_pkg

/* hbfs_timer.sv */
/*
  Saturating cycle counter. Counts while run is high, clears when low.
  Assumes the limit is stable while run is high.
*/
`timescale 1ns/1ps
module hbfs_timer #(
  parameter int W = hbfs_pkg::TIMER_W
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  // ==========================================================================
  // Counter
  logic [W-1:0] countFf;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      countFf <= '0;
    end else if (!run) begin
      countFf <= '0;
    end else if (countFf != limit) begin
      countFf <= countFf + W'(1);
    end
  end

  assign done = run && (countFf == limit);
endmodule : hbfs_timer

/* hbfs_oc_channel.sv */
/*
  Overcurrent supervision of one half-bridge: filter, latch or retry.
  Assumes limit flags from both transistors, synchronous to clock.
*/
`timescale 1ns/1ps
module hbfs_oc_channel (
  input  wire logic                         clock,
  input  wire logic                         rst_b,
  input  wire logic                         logicReset,
  input  wire logic                         hsLimit,
  input  wire logic                         lsLimit,
  input  wire logic                         autoRetry,
  input  wire logic                         clearLatched,
  input  wire logic [hbfs_pkg::TIMER_W-1:0] filterLimit,
  input  wire logic [hbfs_pkg::TIMER_W-1:0] retryLimit,
  output logic                              ocFaultFf
);
  // ==========================================================================
  // Filter and retry timers
  logic limitActive;
  logic filtDone;
  logic retryDone;
  logic nxt_ocFault;

  assign limitActive = hsLimit || lsLimit;

  hbfs_timer u_filter (
    .clock (clock),
    .rst_b (rst_b),
    .run   (limitActive && !logicReset),
    .limit (filterLimit),
    .done  (filtDone)
  );

  hbfs_timer u_retry (
    .clock (clock),
    .rst_b (rst_b),
    .run   (ocFaultFf && autoRetry),
    .limit (retryLimit),
    .done  (retryDone)
  );

  // ==========================================================================
  // Fault flag, set wins over clear
  always_comb begin
    nxt_ocFault = ocFaultFf;
    if (logicReset) begin
      nxt_ocFault = 1'h0;
    end else if (filtDone) begin
      nxt_ocFault = 1'h1;
    end else if (ocFaultFf && !limitActive) begin
      if (autoRetry && retryDone) begin
        nxt_ocFault = 1'h0;
      end else if (!autoRetry && clearLatched) begin
        nxt_ocFault = 1'h0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ocFaultFf <= 1'h0;
    end else begin
      ocFaultFf <= nxt_ocFault;
    end
  end
endmodule : hbfs_oc_channel

/* hbfs_mcu_model.sv */
/* Controller model: drives the sleep pin, pull-up on the fault wire.
   Assumes the design's open-drain enable and one clock. */
`timescale 1ns/1ps
module hbfs_mcu_model (
  input  wire logic clock,
  input  wire logic faultIndicatorNOe,
  output logic      sleepRequestN,
  output logic      faultIndicatorNI
);
  // ==========
  // Fault wire with pull-up
  assign faultIndicatorNI = faultIndicatorNOe ? 1'b0 : 1'b1;
  initial sleepRequestN = 1'b1;
  // Sleep pin low for n cycles
  task automatic sleepLow(input int n);
    @(posedge clock);
    sleepRequestN <= 1'b0;
    repeat (n) @(posedge clock);
    sleepRequestN <= 1'b1;
  endtask : sleepLow
endmodule : hbfs_mcu_model

/* tb_half_bridge_fault_supervisor.sv */
/* Bench: faults, recovery, sleep and registers of the supervisor.
   Assumes the controller model on the sleep pin and fault wire. */
`timescale 1ns/1ps
module tb_half_bridge_fault_supervisor;
  // ==========
  // Signals
  logic clock, rst_b, motorSupplyLockout, supplyBelowReset;
  logic logicSupplyFail, pumpUndervoltage, overtemperatureShutdown;
  logic faultRecoverySelect, sleepRequestN, faultIndicatorNI;
  logic faultIndicatorNO, faultIndicatorNOe, chargePumpEnable;
  logic regulatorEnable, readyForInputs, awvalid, awready, wvalid;
  logic wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  currentLimitHs, currentLimitLs, bridgeEnable, wstrb, m4;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  int          bad_count, num_checks, cyc, seed, i;
  hbfs_supervisor #(.OC_FILTER_CYC(4), .RETRY_CYC(20),
    .SLEEP_ENTRY_CYC(5000), .WAKE_CYC(10)) dut_u (
    .clock, .rst_b, .motorSupplyLockout, .supplyBelowReset,
    .logicSupplyFail, .pumpUndervoltage, .currentLimitHs,
    .currentLimitLs, .overtemperatureShutdown, .faultRecoverySelect,
    .sleepRequestN, .faultIndicatorNI, .faultIndicatorNO,
    .faultIndicatorNOe, .bridgeEnable, .chargePumpEnable,
    .regulatorEnable, .readyForInputs, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
  hbfs_mcu_model mcu_u (.clock, .faultIndicatorNOe, .sleepRequestN,
    .faultIndicatorNI);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ==========
  // Tasks
  task automatic end_sim;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [33:0] s, e);
    num_checks++;
    if (s !== e) begin
      $display("BAD %s exp %h seen %h", nm, e, s);
      bad_count++;
    end
  endtask : check
  task automatic outs(input logic [3:0] b, input logic c, o);
    repeat (20) @(posedge clock);
    check("outs", {bridgeEnable, chargePumpEnable, faultIndicatorNOe},
      {b, c, o});
  endtask : outs
  task automatic clr(input logic p);
    fork
      mcu_u.sleepLow(4100);
      begin
        repeat (2000) @(posedge clock);
        check("pump", chargePumpEnable, p);
      end
    join
    outs(4'hF, 1'b1, 1'b0);
  endtask : clr
  task automatic axWr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    @(posedge clock);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'h7;
    repeat (50) begin
      @(posedge clock);
      if (bvalid) break;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    r = bresp;
    bready <= 1'b0;
  endtask : axWr
  task automatic axRd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clock);
    {araddr, arvalid, rready} <= {a, 2'h3};
    repeat (50) begin
      @(posedge clock);
      if (rvalid) break;
      if (arready) arvalid <= 1'b0;
    end
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask : axRd
  // ==========
  // Timeout
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_sim;
    end
  end
  // ==========
  // Sequence
  initial begin
    seed = 32'hC84C;
    {rst_b, motorSupplyLockout, supplyBelowReset, logicSupplyFail} = 4'h0;
    {pumpUndervoltage, overtemperatureShutdown} = 2'h0;
    {faultRecoverySelect, currentLimitHs, currentLimitLs} = 9'h0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    outs(4'hF, 1'b1, 1'b0);
    check("ready", readyForInputs, 1'b1);
    motorSupplyLockout <= 1'b1;
    outs(4'h0, 1'b0, 1'b1);
    check("pin", faultIndicatorNI, 1'b0);
    supplyBelowReset <= 1'b1;
    outs(4'h0, 1'b0, 1'b0);
    {motorSupplyLockout, supplyBelowReset} <= 2'h0;
    outs(4'hF, 1'b1, 1'b0);
    pumpUndervoltage <= 1'b1;
    outs(4'h0, 1'b1, 1'b1);
    {pumpUndervoltage, logicSupplyFail} <= 2'h1;
    outs(4'h0, 1'b0, 1'b0);
    logicSupplyFail <= 1'b0;
    outs(4'hF, 1'b1, 1'b0);
    for (int m = 0; m < 2; m++) begin
      faultRecoverySelect <= m[0];
      i = {$random(seed)} % 4;
      m4 = 4'h1 << i;
      if ($random(seed) & 1) currentLimitHs <= m4;
      else currentLimitLs <= m4;
      outs(~m4, 1'b1, 1'b1);
      {currentLimitHs, currentLimitLs} <= 8'h0;
      repeat (40) @(posedge clock);
      outs(m ? 4'hF : ~m4, 1'b1, !m);
      if (m == 0) clr(1'b1);
      overtemperatureShutdown <= 1'b1;
      outs(4'h0, 1'b0, 1'b1);
      overtemperatureShutdown <= 1'b0;
      outs(m ? 4'hF : 4'h0, m[0], !m);
      if (m == 0) clr(1'b0);
    end
    fork
      mcu_u.sleepLow(5100);
      begin
        repeat (5080) @(posedge clock);
        check("sleep", {bridgeEnable, chargePumpEnable, regulatorEnable},
          6'h0);
      end
    join
    repeat (2) @(posedge clock);
    check("wake", readyForInputs, 1'b0);
    outs(4'hF, 1'b1, 1'b0);
    m4 = 4'($random(seed));
    axWr(8'h00, {28'h0, m4}, 4'hF, rs);
    check("bresp", rs, 2'h0);
    outs(m4, 1'b1, 1'b0);
    axWr(8'h00, {28'h0, ~m4}, 4'hE, rs);
    check("bresp_nostrb", rs, 2'h0);
    axWr(8'h44, 32'h0000_000F, 4'hF, rs);
    check("bresp_bad", rs, 2'h2);
    axRd(8'h00, rd, rs);
    check("ctrl", rd, {28'h0, m4});
    axRd(8'h04, rd, rs);
    check("status", rd[11:0], 12'hF00);
    axRd(8'h40, rd, rs);
    check("unmapped", {rs, rd}, {2'h2, 32'h0});
    end_sim;
  end
endmodule : tb_half_bridge_fault_supervisor
